/* verilog/tsp_pkg.sv */
// Constants and types for the touch sense power and LED controller.
// Overview of operation
// - Reset pin, companion bus and two select bits choose power state
// - State change clears touches on inactive inputs
// - Standby senses subset, raises interrupts, serves bus
// - Deep sleep: no sensing, static LEDs, no PWM
// - Bus traffic wakes deep sleep only temporarily
// - Wake pin high in deep sleep wakes fully, except in SPI4 mode
// - Companion bus selected means no deep sleep
// - Reset pin high holds and clears everything
// - Reset release sets reset status and interrupt
// - Wake pin output flags standby touches until cleared, except in SPI4 mode
// - Eight LEDs: linked or host, drive, four modes
// - Direct mode follows stimulus with brightness, ramps, delay
// - Pulse once mode counts pulses on press/release
// - Pulse twice mode pulses while held, then count
// - Host LED sequence end may raise attention
// - Round robin scan, baseline compare, touch interrupt
// - Recalibrate disabled inputs leaving standby, all from sleep
// - Calibration request recalibrates, self clears, blocks touches
// - Auto baseline from 64 quiet samples, suspended touched
// - Consecutive negative deltas force recalibration
// - Stuck touch beyond limit forces recalibration
// - Proximity inputs oversampled 1x to 128x
// - Any interrupt sets the pending flag
package tsp_pkg;
   localparam int NCH = 8;
   localparam int MW = 16;
   localparam int ACC_W = 23;
   localparam int SUM_W = 22;
   localparam int CLK_HZ = 50_000_000;
   localparam int CAL_MS = 200;
   localparam int CAL_CYC = CLK_HZ / 1000 * CAL_MS;
   localparam int AVG_SH = 6;
   localparam logic [5:0] AVG_LAST = 6'h3F;
   localparam logic [2:0] CH_LAST = 3'h7;
   localparam logic [7:0] CH_ONE = 8'h01;
   localparam logic [7:0] CH_ALL = 8'hFF;
   localparam logic [8:0] SAMP_ONE = 9'h001;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [23:0] TMR_ONE = 24'h000001;
   typedef enum logic [1:0] {
      PS_ACTIVE = 2'b00,
      PS_STANDBY = 2'b01,
      PS_DEEP = 2'b10,
      PS_HELD = 2'b11
   } tsp_pwr_e;
   typedef enum logic [1:0] {
      SN_IDLE = 2'b00,
      SN_REQ = 2'b01,
      SN_WAIT = 2'b10,
      SN_EVAL = 2'b11
   } tsp_sns_e;
   typedef enum logic [1:0] {
      LM_DIRECT = 2'b00,
      LM_PULSE1 = 2'b01,
      LM_PULSE2 = 2'b10,
      LM_BREATHE = 2'b11
   } tsp_led_e;
endpackage

/* verilog/tsp_led.sv */
// One LED driver with direct, pulse and breathe behaviour.
`timescale 1ns/10ps
module tsp_led
   import tsp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_off,
   input wire logic i_hold,
   input wire logic i_stim,
   input wire logic [1:0] i_mode,
   input wire logic i_invert,
   input wire logic i_push_pull,
   input wire logic i_on_release,
   input wire logic i_ramp,
   input wire logic [2:0] i_pulse_count,
   input wire logic [7:0] i_min_duty,
   input wire logic [7:0] i_max_duty,
   input wire logic [3:0] i_off_delay,
   // Shared timing
   input wire logic i_tick,
   input wire logic [7:0] i_pwm,
   // Pin and completion
   output logic o_led,
   output logic o_led_oe_b,
   output logic o_done
);
   logic act;
   logic act_q;
   logic up_q;
   logic [7:0] duty_q;
   logic [2:0] left_q;
   logic [3:0] dly_q;
   logic cont;
   logic run;
   logic trig;
   logic on;
   logic [7:0] target;

   always_comb begin
      act = i_stim ^ i_invert;
      cont = act && (i_mode == LM_PULSE2 || i_mode == LM_BREATHE);
      run = cont || left_q != '0;
      if (i_mode == LM_PULSE1) begin
         trig = i_on_release ? (act_q && !act) : (act && !act_q);
      end else begin
         trig = i_mode == LM_PULSE2 && act_q && !act;
      end
      target = (act || dly_q != '0) ? i_max_duty : i_min_duty;
      on = (duty_q == DUTY_FULL) || (i_pwm < duty_q);
   end

   // Held state restarts from zero duty so a woken LED starts dark.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         act_q <= 1'b0;
         up_q <= 1'b1;
         duty_q <= '0;
         left_q <= '0;
         dly_q <= '0;
         o_done <= 1'b0;
      end else if (i_off || i_hold) begin
         act_q <= 1'b0;
         up_q <= 1'b1;
         duty_q <= '0;
         left_q <= '0;
         dly_q <= '0;
         o_done <= 1'b0;
      end else begin
         act_q <= act;
         o_done <= 1'b0;
         if (i_mode == LM_DIRECT) begin
            left_q <= '0;
            up_q <= 1'b1;
            if (act) begin
               dly_q <= i_off_delay;
            end else if (i_tick && dly_q != '0) begin
               dly_q <= dly_q - 4'h1;
            end
            if (!i_ramp) begin
               duty_q <= target;
            end else if (i_tick && duty_q < target) begin
               duty_q <= duty_q + 8'h01;
            end else if (i_tick && duty_q > target) begin
               duty_q <= duty_q - 8'h01;
            end
         end else if (trig) begin
            left_q <= i_pulse_count;
            up_q <= 1'b1;
            duty_q <= i_min_duty;
         end else if (!run) begin
            duty_q <= i_min_duty;
            up_q <= 1'b1;
         end else if (i_tick) begin
            if (up_q) begin
               if (duty_q >= i_max_duty) begin
                  up_q <= 1'b0;
               end else begin
                  duty_q <= duty_q + 8'h01;
               end
            end else if (duty_q <= i_min_duty) begin
               up_q <= 1'b1;
               if (!cont && left_q != '0) begin
                  left_q <= left_q - 3'h1;
                  o_done <= left_q == 3'h1;
               end
            end else begin
               duty_q <= duty_q - 8'h01;
            end
         end
      end
   end

   // Open drain sinks to light the LED, so the enable carries the level.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_led <= 1'b0;
         o_led_oe_b <= 1'b1;
      end else if (i_off) begin
         o_led <= 1'b0;
         o_led_oe_b <= 1'b1;
      end else begin
         o_led <= i_push_pull && (i_hold ? i_invert : on);
         o_led_oe_b <= !i_push_pull && !(i_hold ? i_invert : on);
      end
   end
endmodule // tsp_led

/* verilog/tsp_core.sv */
// Power, sensing, recalibration and LED control core of the touch block.
`timescale 1ns/10ps
module tsp_core
   import tsp_pkg::*;
#(
   parameter logic [23:0] CAL_CYCLES = CAL_CYC[23:0]
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_reset_pin,
   // Power control
   input wire logic i_low_power_select,
   input wire logic i_lowest_set,
   input wire logic i_lowest_clr,
   input wire logic i_bus_traffic,
   input wire logic i_spi4_mode,
   input wire logic i_companion_bus,
   // Wake pin
   input wire logic i_wake,
   output logic o_wake,
   output logic o_wake_oe_b,
   // Sensing configuration
   input wire logic [7:0] i_input_enable,
   input wire logic [7:0] i_standby_enable,
   input wire logic [15:0] i_threshold,
   input wire logic [7:0] i_cal_request,
   input wire logic [7:0] i_below_baseline_recal_count,
   input wire logic i_stuck_recal_enable,
   input wire logic [15:0] i_stuck_duration_limit,
   input wire logic [7:0] i_prox_enable,
   input wire logic [2:0] i_prox_samples,
   // Measurement front end
   output logic o_meas_req,
   output logic [2:0] o_meas_chan,
   input wire logic i_meas_done,
   input wire logic [15:0] i_meas_value,
   // Status
   input wire logic i_int_clear,
   output logic o_int_pending,
   output logic o_reset_status,
   output logic [7:0] o_touch,
   output logic [7:0] o_cal_pending,
   output logic [1:0] o_power_state,
   output logic o_bus_awake,
   output logic o_lowest_power_select,
   // LED configuration
   input wire logic [7:0] i_led_linked,
   input wire logic [7:0] i_led_host_on,
   input wire logic [15:0] i_led_mode,
   input wire logic [7:0] i_led_invert,
   input wire logic [7:0] i_led_push_pull,
   input wire logic [7:0] i_led_on_release,
   input wire logic [7:0] i_led_ramp,
   input wire logic [7:0] i_led_alert_en,
   input wire logic [2:0] i_led_pulse_count,
   input wire logic [7:0] i_led_rate,
   input wire logic [7:0] i_led_min_duty,
   input wire logic [7:0] i_led_max_duty,
   input wire logic [3:0] i_led_off_delay,
   // LED pins
   output logic [7:0] o_led,
   output logic [7:0] o_led_oe_b
);
   tsp_pwr_e pwr_q;
   tsp_pwr_e pwr_d;
   tsp_sns_e sn_q;
   logic lowest_q;
   logic awake_q;
   logic chg;
   logic wake_hit;
   logic rst_rel;
   logic [7:0] act_mask;
   logic [7:0] wake_cal;
   logic [2:0] ch_q;
   logic [8:0] samp_q;
   logic [8:0] nsamp;
   logic [ACC_W-1:0] acc_q;
   logic meas_req_q;
   logic [MW-1:0] base_q [NCH];
   logic [SUM_W-1:0] sum_q [NCH];
   logic [5:0] cnt_q [NCH];
   logic [7:0] neg_q [NCH];
   logic [15:0] dur_q [NCH];
   logic [7:0] touch_q;
   logic [7:0] cal_q;
   logic [7:0] cal_set;
   logic [7:0] ch_bit;
   logic [23:0] tmr_q;
   logic int_q;
   logic rstat_q;
   logic wake_q;
   logic wake_oe_b_q;
   logic ev;
   logic calib;
   logic above;
   logic below;
   logic new_touch;
   logic neg_hit;
   logic stuck_hit;
   logic [MW-1:0] avg;
   logic [MW:0] delta;
   logic [7:0] rate_q;
   logic [7:0] pwm_q;
   logic tick_q;
   logic [7:0] led_done;
   logic led_int;

   function automatic logic [7:0] mask_of(input tsp_pwr_e s,
                                          input logic [7:0] en,
                                          input logic [7:0] sb);
      case (s)
         PS_ACTIVE: return en;
         PS_STANDBY: return sb;
         default: return '0;
      endcase
   endfunction

   function automatic logic [2:0] next_ch(input logic [7:0] m,
                                          input logic [2:0] c);
      logic [2:0] n;
      logic found;
      n = c;
      found = 1'b0;
      for (int i = 1; i <= NCH; i++) begin
         if (!found && m[3'(c + 3'(i))]) begin
            n = 3'(c + 3'(i));
            found = 1'b1;
         end
      end
      return n;
   endfunction

   always_comb begin
      if (i_reset_pin) begin
         pwr_d = PS_HELD;
      end else if (lowest_q && !i_companion_bus) begin
         pwr_d = PS_DEEP;
      end else if (i_low_power_select) begin
         pwr_d = PS_STANDBY;
      end else begin
         pwr_d = PS_ACTIVE;
      end
      chg = pwr_d != pwr_q;
      wake_hit = pwr_q == PS_DEEP && !i_spi4_mode && i_wake;
      rst_rel = pwr_q == PS_HELD && !i_reset_pin;
      act_mask = mask_of(pwr_q, i_input_enable, i_standby_enable);
      wake_cal = '0;
      if (chg && pwr_q == PS_STANDBY && pwr_d == PS_ACTIVE) begin
         wake_cal = i_input_enable & ~i_standby_enable;
      end else if (chg && pwr_q == PS_DEEP) begin
         wake_cal = CH_ALL;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lowest_q <= 1'b0;
      end else if (i_reset_pin || wake_hit) begin
         lowest_q <= 1'b0;
      end else if (i_lowest_set && !i_companion_bus) begin
         lowest_q <= 1'b1;
      end else if (i_lowest_clr) begin
         lowest_q <= 1'b0;
      end
   end

   // Bus traffic only flags an awake bus; the select bit is left alone.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pwr_q <= PS_HELD;
         awake_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         awake_q <= pwr_q == PS_DEEP && i_bus_traffic;
      end
   end

   always_comb begin
      nsamp = i_prox_enable[ch_q] ? (SAMP_ONE << i_prox_samples) : SAMP_ONE;
      ch_bit = CH_ONE << ch_q;
      ev = sn_q == SN_EVAL && !chg;
      avg = MW'(acc_q >> (i_prox_enable[ch_q] ? i_prox_samples : 3'h0));
      delta = {1'b0, avg} - {1'b0, base_q[ch_q]};
      below = delta[MW];
      above = !below && delta[MW-1:0] >= i_threshold;
      calib = cal_q[ch_q];
      new_touch = ev && !calib && above && !touch_q[ch_q];
      neg_hit = ev && !calib && below &&
                i_below_baseline_recal_count != '0 &&
                neg_q[ch_q] + 8'h01 == i_below_baseline_recal_count;
      stuck_hit = ev && !calib && above && i_stuck_recal_enable &&
                  dur_q[ch_q] >= i_stuck_duration_limit;
      cal_set = i_cal_request | wake_cal |
                ((neg_hit || stuck_hit) ? ch_bit : '0);
   end

   // A power change restarts the scan at the first input.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sn_q <= SN_IDLE;
         ch_q <= CH_LAST;
         acc_q <= '0;
         samp_q <= '0;
      end else if (i_reset_pin || chg) begin
         sn_q <= SN_IDLE;
         ch_q <= CH_LAST;
         acc_q <= '0;
         samp_q <= '0;
      end else begin
         case (sn_q)
            SN_IDLE: if (act_mask != '0) begin
               ch_q <= next_ch(act_mask, ch_q);
               acc_q <= '0;
               samp_q <= '0;
               sn_q <= SN_REQ;
            end
            SN_REQ: sn_q <= SN_WAIT;
            SN_WAIT: if (i_meas_done) begin
               acc_q <= acc_q + {7'h00, i_meas_value};
               samp_q <= samp_q + SAMP_ONE;
               if (samp_q + SAMP_ONE >= nsamp) begin
                  sn_q <= SN_EVAL;
               end else begin
                  sn_q <= SN_REQ;
               end
            end
            SN_EVAL: sn_q <= SN_IDLE;
            default: sn_q <= SN_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meas_req_q <= 1'b0;
      end else begin
         meas_req_q <= sn_q == SN_REQ && !chg && !i_reset_pin;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < NCH; i++) begin
            base_q[i] <= '0;
            sum_q[i] <= '0;
            cnt_q[i] <= '0;
            neg_q[i] <= '0;
            dur_q[i] <= '0;
         end
      end else if (i_reset_pin) begin
         for (int i = 0; i < NCH; i++) begin
            base_q[i] <= '0;
            sum_q[i] <= '0;
            cnt_q[i] <= '0;
            neg_q[i] <= '0;
            dur_q[i] <= '0;
         end
      end else if (ev && calib) begin
         base_q[ch_q] <= avg;
         sum_q[ch_q] <= '0;
         cnt_q[ch_q] <= '0;
         neg_q[ch_q] <= '0;
         dur_q[ch_q] <= '0;
      end else if (ev) begin
         neg_q[ch_q] <= below && !neg_hit ? neg_q[ch_q] + 8'h01 : '0;
         dur_q[ch_q] <= above ? dur_q[ch_q] + 16'h0001 : '0;
         if (above) begin
            sum_q[ch_q] <= '0;
            cnt_q[ch_q] <= '0;
         end else if (cnt_q[ch_q] == AVG_LAST) begin
            base_q[ch_q] <= MW'((sum_q[ch_q] + {6'h00, avg}) >> AVG_SH);
            sum_q[ch_q] <= '0;
            cnt_q[ch_q] <= '0;
         end else begin
            sum_q[ch_q] <= sum_q[ch_q] + {6'h00, avg};
            cnt_q[ch_q] <= cnt_q[ch_q] + 6'h01;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         touch_q <= '0;
      end else if (i_reset_pin) begin
         touch_q <= '0;
      end else if (chg) begin
         touch_q <= touch_q & mask_of(pwr_d, i_input_enable,
                                      i_standby_enable);
      end else if (ev) begin
         touch_q[ch_q] <= above && !calib;
      end
   end

   // The timer bounds a calibration that an input never gets to finish.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cal_q <= '0;
         tmr_q <= '0;
      end else if (i_reset_pin) begin
         cal_q <= '0;
         tmr_q <= '0;
      end else begin
         cal_q <= (cal_q & ~((ev && calib) ? ch_bit : '0) &
                   ~((tmr_q == TMR_ONE) ? CH_ALL : '0)) | cal_set;
         if (cal_q == '0 && cal_set != '0) begin
            tmr_q <= CAL_CYCLES;
         end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - TMR_ONE;
         end
      end
   end

   assign led_int = |(led_done & ~i_led_linked & i_led_alert_en);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         int_q <= 1'b0;
         rstat_q <= 1'b0;
      end else if (i_reset_pin) begin
         int_q <= 1'b0;
         rstat_q <= 1'b0;
      end else begin
         int_q <= new_touch || rst_rel || led_int || (int_q && !i_int_clear);
         rstat_q <= rst_rel || (rstat_q && !i_int_clear);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wake_q <= 1'b0;
         wake_oe_b_q <= 1'b1;
      end else begin
         wake_oe_b_q <= !(pwr_q == PS_STANDBY && !i_spi4_mode);
         if (pwr_q != PS_STANDBY || i_reset_pin) begin
            wake_q <= 1'b0;
         end else if (new_touch) begin
            wake_q <= 1'b1;
         end else if (!int_q) begin
            wake_q <= 1'b0;
         end
      end
   end

   // One shared PWM ramp keeps all LEDs phase aligned and saves area.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rate_q <= '0;
         pwm_q <= '0;
         tick_q <= 1'b0;
      end else begin
         pwm_q <= pwm_q + 8'h01;
         tick_q <= rate_q == i_led_rate;
         rate_q <= rate_q == i_led_rate ? '0 : rate_q + 8'h01;
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_led
      tsp_led u_led (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .i_off(i_reset_pin || pwr_q == PS_HELD),
         .i_hold(pwr_q == PS_DEEP),
         .i_stim(i_led_linked[g] ? touch_q[g] : i_led_host_on[g]),
         .i_mode(i_led_mode[2*g +: 2]),
         .i_invert(i_led_invert[g]),
         .i_push_pull(i_led_push_pull[g]),
         .i_on_release(i_led_on_release[g]),
         .i_ramp(i_led_ramp[g]),
         .i_pulse_count(i_led_pulse_count),
         .i_min_duty(i_led_min_duty),
         .i_max_duty(i_led_max_duty),
         .i_off_delay(i_led_off_delay),
         .i_tick(tick_q),
         .i_pwm(pwm_q),
         .o_led(o_led[g]),
         .o_led_oe_b(o_led_oe_b[g]),
         .o_done(led_done[g])
      );
   end

   assign o_wake = wake_q;
   assign o_wake_oe_b = wake_oe_b_q;
   assign o_meas_req = meas_req_q;
   assign o_meas_chan = ch_q;
   assign o_int_pending = int_q;
   assign o_reset_status = rstat_q;
   assign o_touch = touch_q;
   assign o_cal_pending = cal_q;
   assign o_power_state = pwr_q;
   assign o_bus_awake = awake_q;
   assign o_lowest_power_select = lowest_q;

   standby_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_reset_pin && !lowest_q && i_low_power_select |=> pwr_q == PS_STANDBY)
      else $error("standby not selected");
   deep_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_reset_pin && lowest_q && !i_companion_bus |=> pwr_q == PS_DEEP)
      else $error("deep sleep not taken");
   no_deep_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_companion_bus |=> pwr_q != PS_DEEP)
      else $error("deep sleep with companion bus");
   chg_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      chg && !i_reset_pin ##1 $stable(i_input_enable) && $stable(i_standby_enable)
      |-> (touch_q & ~act_mask) == '0)
      else $error("touch kept on inactive input");
   deep_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      pwr_q == PS_DEEP |-> !o_meas_req && sn_q == SN_IDLE)
      else $error("sensing in deep sleep");
   bus_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      pwr_q == PS_DEEP && i_bus_traffic && !wake_hit && !i_lowest_clr
      |=> o_bus_awake && o_lowest_power_select)
      else $error("bus wake wrong");
   pin_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      wake_hit && !i_reset_pin |=> !o_lowest_power_select ##1 pwr_q != PS_DEEP)
      else $error("wake pin ignored");
   held_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_reset_pin |=> pwr_q == PS_HELD && o_touch == '0 && !o_int_pending
      && o_cal_pending == '0 && &o_led_oe_b && !o_meas_req)
      else $error("reset pin not holding");
   rst_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      rst_rel |=> o_reset_status && o_int_pending && pwr_q != PS_HELD)
      else $error("reset release not flagged");
   wake_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      pwr_q == PS_STANDBY && !i_spi4_mode && new_touch && !i_reset_pin
      |=> !o_wake_oe_b && o_wake && o_int_pending)
      else $error("wake pin not asserted");
   touch_int_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      new_touch && !i_reset_pin |=> o_int_pending && o_touch[ch_q])
      else $error("touch without interrupt");
   cal_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ev && calib && !i_reset_pin |=> !o_touch[ch_q]
      && base_q[ch_q] == $past(avg))
      else $error("calibration not captured");
endmodule // tsp_core

/* verification/tsp_meas_model.sv */
// Measurement front end model that answers the core's sample requests.
`timescale 1ns/10ps
module tsp_meas_model (
   // Clock, reset and request
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_req,
   input wire logic [2:0] i_chan,
   // Scene and pacing
   input wire logic [7:0] i_touch,
   input wire logic [15:0] i_noise,
   input wire logic i_slow,
   // Answer
   output logic o_done,
   output logic [15:0] o_value
);
   logic busy_q;
   logic [1:0] wait_q;
   // The value toggles outside the answer cycle so that a stale read shows.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_q <= 1'b0;
         wait_q <= 2'h0;
         o_done <= 1'b0;
         o_value <= 16'hFFFF;
      end else begin
         o_done <= 1'b0;
         o_value <= ~o_value;
         if (i_req) begin
            busy_q <= 1'b1;
            wait_q <= i_slow ? 2'h3 : 2'h0;
         end else if (busy_q && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            o_done <= 1'b1;
            o_value <= i_touch[i_chan] ? 16'h0900 : 16'h0100 + i_noise;
         end
      end
   end
endmodule // tsp_meas_model

/* verification/tsp_core_tb.sv */
// Self-checking bench for the touch sense power and LED core.
`timescale 1ns/10ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
module tsp_core_tb;
   logic i_clk, i_rst_b, i_reset_pin, i_low_power_select, i_lowest_set;
   logic i_lowest_clr, i_bus_traffic, i_spi4_mode, i_companion_bus, i_wake;
   logic ext_wake, o_wake, o_wake_oe_b, i_stuck_recal_enable, o_meas_req;
   logic i_meas_done, i_int_clear, o_int_pending, o_reset_status;
   logic o_bus_awake, o_lowest_power_select;
   logic [7:0] i_input_enable, i_standby_enable, i_cal_request, i_prox_enable;
   logic [7:0] i_below_baseline_recal_count, o_touch, o_cal_pending;
   logic [7:0] i_led_linked, i_led_host_on, i_led_invert, i_led_push_pull;
   logic [7:0] i_led_on_release, i_led_ramp, i_led_alert_en, i_led_rate;
   logic [7:0] i_led_min_duty, i_led_max_duty, o_led, o_led_oe_b, touch_mask;
   logic [15:0] i_threshold, i_stuck_duration_limit, i_meas_value;
   logic [15:0] i_led_mode, noise;
   logic [2:0] i_prox_samples, o_meas_chan, i_led_pulse_count;
   logic [3:0] i_led_off_delay;
   logic [1:0] o_power_state, last_pwr;
   logic [1:0] exp_q[$];
   int n_mismatch, check_count, seed, k;
   // The wake pin reads the core's drive when enabled, else the external ext_wake level.
   assign i_wake = !o_wake_oe_b ? o_wake : ext_wake;
   tsp_core #(.CAL_CYCLES(24'h000040)) dut_u (.*);
   tsp_meas_model far_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_req(o_meas_req), .i_chan(o_meas_chan), .i_touch(touch_mask),
      .i_noise(noise), .i_slow(noise[0]), .o_done(i_meas_done),
      .o_value(i_meas_value));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   // Host LED inputs wander at random so the LED drivers see live traffic.
   always @(negedge i_clk) begin
      noise = {12'h000, 4'($random(seed))};
      {i_led_host_on, i_led_ramp, i_led_min_duty, i_led_on_release} =
         $random(seed);
   end
   always @(negedge i_clk) begin
      if (o_power_state !== last_pwr) begin
         if (exp_q.size() == 0) `CHK(o_power_state, last_pwr, "power moved")
         else `CHK(o_power_state, exp_q.pop_front(), "power state")
         last_pwr = o_power_state;
      end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task wait_on(input logic [1:0] v, input logic [7:0] t);
      for (k = 0; k < 600 && o_power_state !== v; k++) cyc(1);
      while (k < 600 && (o_touch & t) !== t) begin
         cyc(1);
         k++;
      end
      if (k == 600) begin
         n_mismatch++;
         report_and_stop;
      end
   endtask
   initial begin
      {i_reset_pin, i_low_power_select, i_lowest_set, i_lowest_clr, ext_wake,
       i_bus_traffic, i_spi4_mode, i_companion_bus, i_stuck_recal_enable,
       i_int_clear, i_cal_request, i_below_baseline_recal_count, i_rst_b,
       i_stuck_duration_limit, i_led_alert_en, i_led_off_delay,
       touch_mask} = '0;
      seed = 32'h4EAD4799;
      {last_pwr, i_input_enable, i_standby_enable} = 18'h3FF04;
      {i_threshold, i_prox_enable, i_prox_samples} = 27'h0200011;
      {i_led_push_pull, i_led_invert, i_led_max_duty} = 24'hFFA5FF;
      {i_led_rate, i_led_pulse_count, i_led_linked} = 19'h0320F;
      i_led_mode = 16'hE4E4;
      cyc(10);
      exp_q.push_back(2'b00);
      i_rst_b = 1'b1;
      wait_on(2'b00, 8'h00);
      cyc(2);
      `CHK({o_reset_status, o_int_pending}, 2'b11, "reset flags")
      pulse(i_int_clear);
      cyc(1);
      `CHK(o_int_pending, 1'b0, "pending clear")
      exp_q.push_back(2'b01);
      i_low_power_select = 1'b1;
      touch_mask = 8'h04;
      wait_on(2'b01, 8'h04);
      cyc(2);
      `CHK({o_wake, o_wake_oe_b, o_int_pending}, 3'b101, "wake out")
      touch_mask = 8'h00;
      pulse(i_int_clear);
      cyc(3);
      `CHK(o_wake, 1'b0, "wake release")
      i_spi4_mode = 1'b1;
      cyc(2);
      `CHK(o_wake_oe_b, 1'b1, "wake pin input")
      i_spi4_mode = 1'b0;
      $display("test standby done");
      exp_q.push_back(2'b10);
      pulse(i_lowest_set);
      wait_on(2'b10, 8'h00);
      cyc(1);
      `CHK({o_led_oe_b, o_led, o_touch}, 24'h00A500, "deep pins")
      i_bus_traffic = 1'b1;
      cyc(2);
      `CHK({o_bus_awake, o_power_state}, 3'b110, "bus wake")
      {i_bus_traffic, i_low_power_select, ext_wake} = 3'b001;
      exp_q.push_back(2'b00);
      wait_on(2'b00, 8'h00);
      `CHK(o_cal_pending, 8'hFF, "recal all")
      {ext_wake, i_companion_bus} = 2'b01;
      pulse(i_lowest_set);
      cyc(3);
      `CHK({o_lowest_power_select, o_power_state}, 3'b000, "no deep")
      i_companion_bus = 1'b0;
      exp_q.push_back(2'b10);
      pulse(i_lowest_set);
      wait_on(2'b10, 8'h00);
      exp_q.push_back(2'b00);
      pulse(i_lowest_clr);
      wait_on(2'b00, 8'h00);
      $display("test deep done");
      cyc(200);
      i_cal_request = 8'h10;
      cyc(1);
      i_cal_request = 8'h00;
      `CHK(o_cal_pending, 8'h10, "cal request")
      cyc(80);
      `CHK(o_cal_pending, 8'h00, "cal self clear")
      touch_mask = 8'h80;
      wait_on(2'b00, 8'h80);
      `CHK({o_touch, o_int_pending}, 9'h101, "touch flag")
      exp_q.push_back(2'b11);
      i_reset_pin = 1'b1;
      wait_on(2'b11, 8'h00);
      cyc(1);
      `CHK({o_touch, o_led_oe_b}, 16'h00FF, "held reset")
      exp_q.push_back(2'b00);
      i_reset_pin = 1'b0;
      wait_on(2'b00, 8'h00);
      cyc(2);
      `CHK(o_reset_status, 1'b1, "pin release")
      $display("test reset pin done");
      report_and_stop;
   end
endmodule // tsp_core_tb
